// ---- pkg/ppo_params.svh ----
// Offsets, field positions, masks, reset values and timing counts of the port block.
// Included by the package and the design; definitions only.
`ifndef PPO_PARAMS_SVH
`define PPO_PARAMS_SVH

// Port indices, also word index of each bidirectional port register
`define PPO_NPORT      6
`define PPO_P5         3'h0
`define PPO_P6         3'h1
`define PPO_P7         3'h2
`define PPO_P8         3'h3
`define PPO_PC         3'h4
`define PPO_PD         3'h5

// Byte offsets of the other registers
`define PPO_OFF_P2     8'h18
`define PPO_OFF_PA     8'h1C
`define PPO_OFF_MISC   8'h20

// Field positions in a port register
`define PPO_DIR_LSB    8
`define PPO_PUL_LSB    16
`define PPO_IN_LSB     24
// Fields of the port 2 register
`define PPO_RSTBIT     7
// Fields of the misc register
`define PPO_P7DN_BIT   0
`define PPO_PADN_BIT   1
`define PPO_SYNC_LSB   8
`define PPO_MODE_BIT   16
`define PPO_READY_BIT  17

// Width masks and reset values
`define PPO_MASK5      8'h1F
`define PPO_MASK4      8'h0F
`define PPO_MASK8      8'hFF
`define PPO_MASK7      7'h7F
`define PPO_RST_BYTE   8'h00
`define PPO_RST_P2     7'h00
`define PPO_RSTBIT_RST 1'b1

// Clock stabilisation wait after the reset pin goes high
`define PPO_CLK_MHZ    250
`define PPO_STAB_NS    1000
`define PPO_STAB_CYC   ((`PPO_STAB_NS * `PPO_CLK_MHZ + 999) / 1000)
`define PPO_STAB_W     9

`endif

// ---- pkg/ppo_pkg.sv ----
// Types shared by the port block.
// Assumes ppo_params.svh is on the include path.
`include "ppo_params.svh"
package ppo_pkg;
  typedef enum logic [2:0]
  {
    PPO_HOLD = 3'b001,
    PPO_WAIT = 3'b010,
    PPO_RUN  = 3'b100
  } ppo_state_t;
  typedef logic [7:0] ppo_byte_t;
endpackage

// ---- src/ppo_top.sv ----
// Port logic for ports 5 to 8, 2, A, C and D with external bus override and reset pin.
// Assumes an APB master on pclk; pins are synchronised here; bus signals come on pclk.
// What this block does
// - Every bidirectional port bit has its own direction bit.
// - Every port bit has its own pull enable in the port's pull register.
// - Reset leaves bidirectional bits as inputs with pulls off, pins undriven.
// - Port 2 is seven input bits, own pull enables, all off after reset.
// - Writing zero to the reset-pin bit starts software reset, pin pulled low only.
// - Reset pin low holds state initialised; after high, wait clock settle, then run.
// - Port 5 has five bits; processor mode forces strobes and top address out.
// - Processor mode forces port 6 out carrying address bits 0 to 7.
// - Processor mode forces port 7 out carrying address bits 8 to 15.
// - Processor mode makes port 8 the data bus, starting as input.
// - Single-chip mode brings ports 5 to 8 up as plain inputs, pulls off.
// - Ports 7 and A select pull-up or pull-down for the whole port.
// - Port A is eight input bits, pulls off after reset.
// - Port C has four bidirectional bits, inputs with pulls off after reset.
// - Port D bit n may carry synchronous output latch bit n.
// - Processor mode puts address bits 16 and 17 on port 5 bits 3 and 4.
// - A per-bit select register picks synchronous output on port D.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "ppo_params.svh"
module ppo_top
  import ppo_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode strap and reset pin
  input  wire logic        mode_processor_pin,
  input  wire logic        reset_pin_low_active_in,
  output logic             reset_pin_low_active_out,
  output logic             reset_pin_low_active_oe_n,
  output logic             core_ready,
  // External memory interface
  input  wire logic [17:0] ext_addr,
  input  wire logic        ext_write_strobe_n,
  input  wire logic        ext_read_strobe_n,
  input  wire logic        ext_chip_select_n,
  input  wire logic [7:0]  ext_data_out,
  input  wire logic        ext_data_drive,
  output logic      [7:0]  ext_data_in,
  // Timer synchronous output latch
  input  wire logic [7:0]  sync_out_latch,
  // Bidirectional ports, one byte each: 5, 6, 7, 8, C, D
  input  wire logic [47:0] port_pin_in,
  output logic      [47:0] port_pin_out,
  output logic      [47:0] port_pin_oe_n,
  output logic      [47:0] port_pull_up,
  output logic      [7:0]  port7_pull_down,
  // Input-only ports
  input  wire logic [6:0]  port2_pin_in,
  output logic      [6:0]  port2_pull_up,
  input  wire logic [7:0]  porta_pin_in,
  output logic      [7:0]  porta_pull_up,
  output logic      [7:0]  porta_pull_down
);

  function automatic ppo_byte_t port_mask(input logic [2:0] i);
    port_mask = (i == `PPO_P5) ? `PPO_MASK5 : (i == `PPO_PC) ? `PPO_MASK4 : `PPO_MASK8;
  endfunction

  // Synchronisers
  logic [47:0] pin_s1_q, pin_s2_q;
  logic [6:0]  p2_s1_q, p2_s2_q;
  logic [7:0]  pa_s1_q, pa_s2_q;
  logic        rst_s1_q, rst_s2_q, mode_s1_q, mode_s2_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
      p2_s1_q   <= '0;
      p2_s2_q   <= '0;
      pa_s1_q   <= '0;
      pa_s2_q   <= '0;
      rst_s1_q  <= 1'b0;
      rst_s2_q  <= 1'b0;
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end
    else
    begin
      pin_s1_q  <= port_pin_in;
      pin_s2_q  <= pin_s1_q;
      p2_s1_q   <= port2_pin_in;
      p2_s2_q   <= p2_s1_q;
      pa_s1_q   <= porta_pin_in;
      pa_s2_q   <= pa_s1_q;
      rst_s1_q  <= reset_pin_low_active_in;
      rst_s2_q  <= rst_s1_q;
      mode_s1_q <= mode_processor_pin;
      mode_s2_q <= mode_s1_q;
    end
  end

  // Reset sequencing
  ppo_state_t             state_q, state_d;
  logic [`PPO_STAB_W-1:0] stab_q;
  logic                   proc_q;
  wire                    init    = !rst_s2_q;
  wire                    stab_end = (stab_q == `PPO_STAB_W'(`PPO_STAB_CYC - 1));

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PPO_HOLD: state_d = PPO_WAIT;
      PPO_WAIT: state_d = stab_end ? PPO_RUN : PPO_WAIT;
      PPO_RUN:  state_d = PPO_RUN;
      default:  state_d = PPO_HOLD;
    endcase
    if (init)
      state_d = PPO_HOLD;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= PPO_HOLD;
      stab_q  <= '0;
      proc_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      stab_q  <= (state_q == PPO_WAIT) ? stab_q + 1'b1 : '0;
      if (init)
        proc_q <= 1'b0;
      else if (state_q == PPO_WAIT && stab_end)
        proc_q <= mode_s2_q;
    end
  end

  wire run = (state_q == PPO_RUN);

  // Registers
  ppo_byte_t out_q [`PPO_NPORT];
  ppo_byte_t dir_q [`PPO_NPORT];
  ppo_byte_t pul_q [`PPO_NPORT];
  logic [6:0] p2pul_q;
  logic       rstbit_q;
  ppo_byte_t  papul_q, sync_sel_q;
  logic       p7dn_q, padn_q;

  wire       setup = psel && !penable;
  wire       wr    = psel && penable && pwrite;
  wire [5:0] widx  = paddr[7:2];
  wire       is_p2 = (paddr == `PPO_OFF_P2);
  wire       is_pa = (paddr == `PPO_OFF_PA);
  wire       is_ms = (paddr == `PPO_OFF_MISC);
  wire       is_pt = (paddr[1:0] == 2'h0) && (widx < 6'(`PPO_NPORT));
  wire       mapped = is_pt || is_p2 || is_pa || is_ms;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < `PPO_NPORT; i++)
      begin
        out_q[i] <= `PPO_RST_BYTE;
        dir_q[i] <= `PPO_RST_BYTE;
        pul_q[i] <= `PPO_RST_BYTE;
      end
      p2pul_q    <= `PPO_RST_P2;
      rstbit_q   <= `PPO_RSTBIT_RST;
      papul_q    <= `PPO_RST_BYTE;
      sync_sel_q <= `PPO_RST_BYTE;
      p7dn_q     <= 1'b0;
      padn_q     <= 1'b0;
    end
    else if (init)
    begin
      for (int i = 0; i < `PPO_NPORT; i++)
      begin
        out_q[i] <= `PPO_RST_BYTE;
        dir_q[i] <= `PPO_RST_BYTE;
        pul_q[i] <= `PPO_RST_BYTE;
      end
      p2pul_q    <= `PPO_RST_P2;
      rstbit_q   <= `PPO_RSTBIT_RST;
      papul_q    <= `PPO_RST_BYTE;
      sync_sel_q <= `PPO_RST_BYTE;
      p7dn_q     <= 1'b0;
      padn_q     <= 1'b0;
    end
    else if (wr)
    begin
      for (int i = 0; i < `PPO_NPORT; i++)
        if (is_pt && widx == 6'(i))
        begin
          out_q[i] <= pwdata[7:0] & port_mask(3'(i));
          dir_q[i] <= pwdata[`PPO_DIR_LSB +: 8] & port_mask(3'(i));
          pul_q[i] <= pwdata[`PPO_PUL_LSB +: 8] & port_mask(3'(i));
        end
      if (is_p2)
      begin
        p2pul_q  <= pwdata[6:0];
        rstbit_q <= pwdata[`PPO_RSTBIT];
      end
      if (is_pa)
        papul_q <= pwdata[7:0];
      if (is_ms)
      begin
        p7dn_q     <= pwdata[`PPO_P7DN_BIT];
        padn_q     <= pwdata[`PPO_PADN_BIT];
        sync_sel_q <= pwdata[`PPO_SYNC_LSB +: 8];
      end
    end
  end

  // Effective pin control
  ppo_byte_t dir_eff [`PPO_NPORT];
  ppo_byte_t val_eff [`PPO_NPORT];
  ppo_byte_t pu_eff  [`PPO_NPORT];
  logic [47:0] out_d, oe_n_d, pu_d;

  always_comb
  begin
    for (int i = 0; i < `PPO_NPORT; i++)
    begin
      dir_eff[i] = run ? dir_q[i] : `PPO_RST_BYTE;
      val_eff[i] = out_q[i];
    end
    val_eff[`PPO_PD] = (sync_sel_q & sync_out_latch) | (~sync_sel_q & out_q[`PPO_PD]);
    if (run && proc_q)
    begin
      dir_eff[`PPO_P5] = `PPO_MASK5;
      val_eff[`PPO_P5] = {3'h0, ext_addr[17:16], ext_chip_select_n,
                          ext_read_strobe_n, ext_write_strobe_n};
      dir_eff[`PPO_P6] = `PPO_MASK8;
      val_eff[`PPO_P6] = ext_addr[7:0];
      dir_eff[`PPO_P7] = `PPO_MASK8;
      val_eff[`PPO_P7] = ext_addr[15:8];
      dir_eff[`PPO_P8] = {8{ext_data_drive}};
      val_eff[`PPO_P8] = ext_data_out;
    end
    for (int i = 0; i < `PPO_NPORT; i++)
    begin
      pu_eff[i] = run ? (pul_q[i] & ~dir_eff[i]) : `PPO_RST_BYTE;
      out_d[i*8 +: 8]  = val_eff[i] & port_mask(3'(i));
      oe_n_d[i*8 +: 8] = ~(dir_eff[i] & port_mask(3'(i)));
    end
    for (int i = 0; i < `PPO_NPORT; i++)
      pu_d[i*8 +: 8] = (i == 2) ? (pu_eff[i] & {8{!p7dn_q}}) : pu_eff[i];
  end

  wire [31:0] rd_port = {pin_s2_q[widx[2:0]*8 +: 8], pul_q[widx[2:0]],
                         dir_q[widx[2:0]], out_q[widx[2:0]]};
  wire [31:0] rd_p2   = {8'h00, rst_s2_q, p2_s2_q, 8'h00, rstbit_q, p2pul_q};
  wire [31:0] rd_pa   = {8'h00, pa_s2_q, 8'h00, papul_q};
  wire [31:0] rd_ms   = {14'h0000, run, proc_q, sync_sel_q, 6'h00, padn_q, p7dn_q};
  wire [31:0] rd_d    = is_pt ? rd_port : is_p2 ? rd_p2 : is_pa ? rd_pa :
                        is_ms ? rd_ms : 32'h0000_0000;

  // Output flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata                    <= '0;
      pready                    <= 1'b0;
      pslverr                   <= 1'b0;
      reset_pin_low_active_out  <= 1'b0;
      reset_pin_low_active_oe_n <= 1'b1;
      core_ready                <= 1'b0;
      ext_data_in               <= '0;
      port_pin_out              <= '0;
      port_pin_oe_n             <= '1;
      port_pull_up              <= '0;
      port7_pull_down           <= '0;
      port2_pull_up             <= '0;
      porta_pull_up             <= '0;
      porta_pull_down           <= '0;
    end
    else
    begin
      prdata                    <= setup ? rd_d : prdata;
      pready                    <= setup;
      pslverr                   <= setup && !mapped;
      reset_pin_low_active_oe_n <= rstbit_q;
      core_ready                <= run;
      ext_data_in               <= pin_s2_q[`PPO_P8*8 +: 8];
      port_pin_out              <= out_d;
      port_pin_oe_n             <= oe_n_d;
      port_pull_up              <= pu_d;
      port7_pull_down           <= pu_eff[`PPO_P7] & {8{p7dn_q}};
      port2_pull_up             <= run ? p2pul_q : `PPO_RST_P2;
      porta_pull_up             <= run ? (papul_q & {8{!padn_q}}) : `PPO_RST_BYTE;
      porta_pull_down           <= run ? (papul_q & {8{padn_q}}) : `PPO_RST_BYTE;
    end
  end

endmodule

// ---- testbench/ppo_top_monitor.sv ----
// Checker of the port block, bound to ppo_top.
// Assumes the mode strap changes only while presetn is low.
`timescale 1ns/1ns
module ppo_top_monitor
  import ppo_pkg::*;
(
  // Clock, reset, bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Mode and reset pin
  input wire logic        mode_processor_pin,
  input wire logic        reset_pin_low_active_in,
  input wire logic        reset_pin_low_active_out,
  input wire logic        core_ready,
  // Memory interface
  input wire logic [17:0] ext_addr,
  input wire logic        ext_write_strobe_n,
  input wire logic        ext_read_strobe_n,
  input wire logic        ext_chip_select_n,
  input wire logic        ext_data_drive,
  // Pins
  input wire logic [47:0] port_pin_out,
  input wire logic [47:0] port_pin_oe_n,
  input wire logic [47:0] port_pull_up,
  input wire logic [7:0]  port7_pull_down
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic proc_run;
  wire logic idle;
  assign proc_run = core_ready && mode_processor_pin;
  assign idle = &port_pin_oe_n && port_pull_up == 48'h0 && port7_pull_down == 8'h00;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bus_s;
    proc_run && $past(proc_run);
  endsequence
  apb_answer_a: assert property (setup_s |=> pready)
    else $error("ready missing after setup");
  ready_only_a: assert property (!setup_s |=> !pready)
    else $error("ready without setup");
  drain_low_a: assert property (reset_pin_low_active_out == 1'b0)
    else $error("reset pin driven high");
  idle_pins_a: assert property (!core_ready [*4] |-> $past(idle))
    else $error("pins live before run");
  addr_low_a: assert property (bus_s |-> port_pin_out[15:8] == $past(ext_addr[7:0])
    && port_pin_oe_n[15:8] == 8'h00) else $error("port 6 address wrong");
  addr_mid_a: assert property (bus_s |-> port_pin_out[23:16] == $past(ext_addr[15:8])
    && port_pin_oe_n[23:16] == 8'h00) else $error("port 7 address wrong");
  strobe_pins_a: assert property (bus_s |-> port_pin_oe_n[4:0] == 5'h00
    && port_pin_out[4:0] == $past({ext_addr[17:16], ext_chip_select_n,
    ext_read_strobe_n, ext_write_strobe_n})) else $error("port 5 bus pins wrong");
  data_dir_a: assert property (bus_s |->
    port_pin_oe_n[31:24] == {8{~$past(ext_data_drive)}}) else $error("data bus direction wrong");
  unused_bits_a: assert property (port_pin_out[7:5] == 3'h0 && &port_pin_oe_n[7:5]
    && &port_pin_oe_n[39:36] && port_pull_up[7:5] == 3'h0) else $error("unused bit active");
  pull_input_a: assert property ((port_pull_up & ~port_pin_oe_n) == 48'h0
    && (port7_pull_down & ~port_pin_oe_n[23:16]) == 8'h00) else $error("pull on output");
  hold_low_a: assert property (!reset_pin_low_active_in [*4] |=> !core_ready)
    else $error("running while reset pin low");
  settle_wait_a: assert property ($rose(core_ready) |->
    $past(reset_pin_low_active_in, 250)) else $error("run before clock settle wait");
endmodule
bind ppo_top ppo_top_monitor u_mon (.*);

// ---- testbench/ppo_pin_model.sv ----
// Outside world of the port pins: loads, drivers and the reset wire.
// Assumes the device drives a pin only while its oe_n bit is low.
`timescale 1ns/1ns
module ppo_pin_model (
  // Clock
  input  wire logic        pclk,
  // Device pin drivers
  input  wire logic [47:0] port_pin_out,
  input  wire logic [47:0] port_pin_oe_n,
  input  wire logic [47:0] port_pull_up,
  input  wire logic [7:0]  port7_pull_down,
  input  wire logic        reset_pin_low_active_oe_n,
  // Outside drivers
  input  wire logic [47:0] env_val,
  input  wire logic [47:0] env_en,
  // Resolved levels
  output logic      [47:0] port_pin_in,
  output logic             reset_pin_low_active_in
);
  logic [47:0] float_q = 48'h0;
  logic [47:0] down;
  always @(posedge pclk) float_q <= ~float_q;
  assign down = {24'h0, port7_pull_down, 16'h0};
  // Device first, then outside drivers, then pulls, else a toggling level
  assign port_pin_in = ~port_pin_oe_n & port_pin_out | port_pin_oe_n & (env_en & env_val
    | ~env_en & (port_pull_up | ~down & float_q));
  // Open drain with pull-up: low only while sunk
  assign reset_pin_low_active_in = reset_pin_low_active_oe_n;
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench of the port block: APB master, pin model, checker.
// Assumes the checker is bound from its own file; clock 250 MHz.
`timescale 1ns/1ns
module testbench
  import ppo_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [23:0] r; int k;
    logic [7:0] o; logic [7:0] e; logic [7:0] p;} ppo_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mode_processor_pin = 0;
  logic ext_write_strobe_n = 0, ext_read_strobe_n = 1, ext_chip_select_n = 0;
  logic ext_data_drive = 0, pready, pslverr, core_ready, reset_pin_low_active_in;
  logic reset_pin_low_active_out, reset_pin_low_active_oe_n;
  logic [7:0]  paddr = 8'h00, ext_data_out = 8'h69, sync_out_latch = 8'hA5, porta_pin_in = 8'h5A;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [17:0] ext_addr = 18'h2A5C3;
  logic [6:0]  port2_pin_in = 7'h55, port2_pull_up;
  logic [7:0]  ext_data_in, port7_pull_down, porta_pull_up, porta_pull_down;
  logic [47:0] port_pin_in, port_pin_out, port_pin_oe_n, port_pull_up;
  logic [47:0] env_val = 48'h00003C000000, env_en = 48'h0000FF000000;
  logic        er;
  int          fails = 0, total_checks = 0, n;
  ppo_row_t rows [6] = '{
    '{8'h00, 32'h00FF1AFF, 24'h1F1A1F, 0, 8'h1A, 8'hE5, 8'h05},
    '{8'h04, 32'h000FF05A, 24'h0FF05A, 1, 8'h50, 8'h0F, 8'h0F},
    '{8'h08, 32'h00FF00C3, 24'hFF00C3, 2, 8'h00, 8'hFF, 8'hFF},
    '{8'h0C, 32'h0000FF96, 24'h00FF96, 3, 8'h96, 8'h00, 8'h00},
    '{8'h10, 32'h00FF05FF, 24'h0F050F, 4, 8'h05, 8'hFA, 8'h0A},
    '{8'h14, 32'h00AA553C, 24'hAA553C, 5, 8'h14, 8'hAA, 8'hAA}};
  ppo_top uut (.*);
  ppo_pin_model model (.*);
  always #2 pclk = ~pclk;
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string s, logic [47:0] e, logic [47:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      fails++;
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    while (core_ready !== 1'b1 && k < 900)
    begin
      @(posedge pclk);
      k++;
    end
    chk("core_ready", 1, core_ready);
    if (core_ready !== 1'b1)
      results();
  endtask
  task automatic pulse_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("oe_n in reset", {48{1'b1}}, port_pin_oe_n);
    presetn <= 1'b1;
    wait_ready();
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_ready();
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      chk("port reg", rows[i].r, rd[23:0]);
      repeat (2) @(posedge pclk);
      chk("oe_n", rows[i].e, port_pin_oe_n[8*rows[i].k +: 8]);
      chk("pull", rows[i].p, port_pull_up[8*rows[i].k +: 8]);
      chk("out", rows[i].o, port_pin_out[8*rows[i].k +: 8] & ~rows[i].e);
    end
    pulse_reset();
    for (int a = 0; a < 6; a++)
    begin
      apb(1'b0, 8'(4 * a), 32'h0);
      chk("reg after reset", 0, rd[23:0]);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("port2 reset", 8'h80, rd[7:0]);
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 33'h100000000, {er, rd});
    apb(1'b1, 8'h08, 32'h00FF0000);
    apb(1'b1, 8'h1C, 32'h0000003C);
    apb(1'b1, 8'h20, 32'h0000F003);
    apb(1'b1, 8'h14, 32'h0000FF00);
    apb(1'b1, 8'h18, 32'h000000FF);
    apb(1'b0, 8'h1C, 32'h0);
    chk("port A pins", 8'h5A, rd[23:16]);
    chk("pull down", 32'hFF003C00, {port7_pull_down, port_pull_up[23:16], porta_pull_down,
      porta_pull_up});
    chk("port2 pulls", 7'h7F, port2_pull_up);
    chk("sync out", 8'hA0, port_pin_out[47:40]);
    apb(1'b1, 8'h18, 32'h0);
    n = 0;
    while (reset_pin_low_active_oe_n !== 1'b0 && n < 10)
    begin
      @(posedge pclk);
      n++;
    end
    chk("soft reset drive", 0, reset_pin_low_active_oe_n);
    if (reset_pin_low_active_oe_n !== 1'b0)
      results();
    repeat (8) @(posedge pclk);
    chk("soft reset state", 0, core_ready);
    wait_ready();
    apb(1'b0, 8'h14, 32'h0);
    chk("port D after soft reset", 0, rd[23:0]);
    mode_processor_pin <= 1'b1;
    pulse_reset();
    repeat (2) @(posedge pclk);
    chk("data bus input", 16'hFF3C, {port_pin_oe_n[31:24], ext_data_in});
    apb(1'b1, 8'h04, 32'h000000FF);
    ext_data_drive <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("bus pins oe_n", 32'h000000E0, port_pin_oe_n[31:0]);
    chk("bus pins out", 32'h69A5C312, port_pin_out[31:0]);
    results();
  end
endmodule
